// ===== motor_status_readout.sv
// two-wire slave that answers the status, position and otp dump reads
// Notes on behaviour
// - command byte 0x81 selects the full status read, 0xFC the position read, 0x82 the otp dump read.
// - the slave address is two fixed ones, four otp address bits and the pin address bit.
// - the master acks every response byte but the last, and a missing ack ends the answer and frees the line.
// - a full status read asks the fault flags to be cleared once they have been reported.
// - status byte one holds run and hold current, byte two max and min velocity.
// - status byte three holds ramp bypass, microstep resolution, direction and acceleration.
// - status byte four holds the six fault flags from bit 7 down and the temperature level in bits 1 to 0.
// - status byte five holds motion status, switch state, both overcurrents, a one and pump failure.
// - actual and target position are sent as signed sixteen-bit values.
// - the secure position low byte goes whole, its upper bits sit low in the next byte padded with ones.
// - the position answer sends actual high, low, target high, low, then the secure position bytes.
// - the otp dump sends the eight otp bytes in ascending address order.
// - the position answer also carries stall detection information.
module motor_status_readout (
  // clock, reset, enable
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic CE,
  // two-wire bus pins
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  // node address
  input wire logic [3:0] OTP_ADDRESS_BITS,
  input wire logic PIN_ADDRESS_BIT,
  // reported state
  input wire motor_status_readout_pkg::status_s STATUS,
  input wire motor_status_readout_pkg::position_s POSITION,
  input wire motor_status_readout_pkg::otp_t OTP_BYTES,
  // flag clear request
  output logic FLAG_CLEAR
);
  import motor_status_readout_pkg::*;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_ADDR = 7'b0000010,
    ST_AACK = 7'b0000100,
    ST_CMD = 7'b0001000,
    ST_CACK = 7'b0010000,
    ST_TX = 7'b0100000,
    ST_MACK = 7'b1000000
  } state_e;

  state_e state_reg;
  logic scl_m_reg, scl_s_reg, scl_d_reg;
  logic pin_m_reg, pin_s_reg;
  logic sda_m_reg, sda_s_reg, sda_d_reg;
  logic [7:0] sh_reg;
  logic [3:0] bit_reg;
  logic [3:0] idx_reg;
  logic [7:0] cmd_reg;
  logic oe_n_reg;
  logic clr_reg;
  status_s snap_reg;
  position_s psnap_reg;
  logic [6:0] own_addr;
  logic start_ev, stop_ev, scl_rise, scl_fall;
  logic byte_done, load_next, load_first;
  logic [7:0] next_byte;

  // ----------------------------------------
  // response byte decoding
  // ----------------------------------------
  function automatic logic [7:0] resp_byte(input logic [7:0] cmd, input logic [3:0] i,
      input status_s s, input position_s p, input otp_t o, input logic [6:0] a);
    logic [7:0] b;
    b = FILL_BYTE;
    if (cmd == CMD_STATUS) begin
      unique case (i)
        4'h1: b = {ADDR_ECHO_MARK, a[4:0]};
        4'h2: b = {s.run_current, s.hold_current};
        4'h3: b = {s.max_velocity, s.min_velocity};
        4'h4: b = {s.ramp_bypass, s.microstep_resolution, s.direction, s.acceleration};
        4'h5: b = {s.logic_supply_reset_flag, s.lost_steps_flag, s.electrical_defect,
                   s.supply_undervoltage, s.thermal_shutdown, s.thermal_warning,
                   s.temperature_level};
        4'h6: b = {s.motion_status, s.external_switch_state, s.overcurrent_x_coil,
                   s.overcurrent_y_coil, 1'b1, s.pump_failure};
        default: b = FILL_BYTE;
      endcase
    end else if (cmd == CMD_POS) begin
      unique case (i)
        4'h1: b = {ADDR_ECHO_MARK, a[4:0]};
        4'h2: b = p.actual_position[15:8];
        4'h3: b = p.actual_position[7:0];
        4'h4: b = p.target_position[15:8];
        4'h5: b = p.target_position[7:0];
        4'h6: b = p.secure_position[7:0];
        4'h7: b = {SEC_PAD, p.secure_position[10:8]};
        4'h8: b = {STALL_PAD, p.stall_info};
        default: b = FILL_BYTE;
      endcase
    end else if (cmd == CMD_OTP && i >= FIRST_IDX && i < LAST_IDX) begin
      b = o[3'(i - FIRST_IDX)];
    end
    return b;
  endfunction

  // ----------------------------------------
  // pin synchronisers and bus events
  // ----------------------------------------
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      scl_m_reg <= 1'b1;
      scl_s_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      pin_m_reg <= 1'b0;
      pin_s_reg <= 1'b0;
    end else if (CE) begin
      scl_m_reg <= SCL_IN;
      scl_s_reg <= scl_m_reg;
      scl_d_reg <= scl_s_reg;
      sda_m_reg <= SDA_IN;
      sda_s_reg <= sda_m_reg;
      sda_d_reg <= sda_s_reg;
      // the address strap is a pin as well, so it passes the same two flops
      pin_m_reg <= PIN_ADDRESS_BIT;
      pin_s_reg <= pin_m_reg;
    end
  end

  assign own_addr = {ADDR_FIXED, OTP_ADDRESS_BITS, pin_s_reg};
  assign start_ev = scl_s_reg & scl_d_reg & sda_d_reg & ~sda_s_reg;
  assign stop_ev = scl_s_reg & scl_d_reg & ~sda_d_reg & sda_s_reg;
  assign scl_rise = scl_s_reg & ~scl_d_reg;
  assign scl_fall = ~scl_s_reg & scl_d_reg;
  assign byte_done = scl_fall && bit_reg == BITS_PER_BYTE;
  assign load_first = state_reg == ST_AACK && scl_fall && sh_reg[0];
  assign load_next = state_reg == ST_MACK && scl_fall;
  assign next_byte = resp_byte(cmd_reg, load_first ? FIRST_IDX : idx_reg,
                               snap_reg, psnap_reg, OTP_BYTES, own_addr);

  // ----------------------------------------
  // transfer state machine
  // ----------------------------------------
  // start and stop win over any state, so a broken frame always resyncs
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg <= ST_IDLE;
      sh_reg <= SHIFT_RESET;
      bit_reg <= COUNT_RESET;
      idx_reg <= COUNT_RESET;
      oe_n_reg <= 1'b1;
    end else if (CE) begin
      if (start_ev) begin
        state_reg <= ST_ADDR;
        bit_reg <= COUNT_RESET;
        oe_n_reg <= 1'b1;
      end else if (stop_ev) begin
        state_reg <= ST_IDLE;
        oe_n_reg <= 1'b1;
      end else begin
        unique case (state_reg)
          ST_IDLE: state_reg <= ST_IDLE;
          ST_ADDR, ST_CMD: begin
            if (scl_rise) begin
              sh_reg <= {sh_reg[6:0], sda_s_reg};
              bit_reg <= bit_reg + 4'h1;
            end else if (byte_done) begin
              if (state_reg == ST_CMD) begin
                state_reg <= ST_CACK;
                oe_n_reg <= 1'b0;
              end else if (sh_reg[7:1] == own_addr) begin
                state_reg <= ST_AACK;
                oe_n_reg <= 1'b0;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          ST_AACK: begin
            if (scl_fall) begin
              bit_reg <= COUNT_RESET;
              if (sh_reg[0]) begin
                sh_reg <= next_byte;
                oe_n_reg <= next_byte[7];
                idx_reg <= FIRST_IDX + 4'h1;
                state_reg <= ST_TX;
              end else begin
                oe_n_reg <= 1'b1;
                state_reg <= ST_CMD;
              end
            end
          end
          // trailing write bytes are ignored; write commands live elsewhere
          ST_CACK: begin
            if (scl_fall) begin
              oe_n_reg <= 1'b1;
              state_reg <= ST_IDLE;
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              bit_reg <= bit_reg + 4'h1;
            end else if (byte_done) begin
              oe_n_reg <= 1'b1;
              state_reg <= ST_MACK;
            end else if (scl_fall) begin
              sh_reg <= {sh_reg[6:0], 1'b1};
              oe_n_reg <= sh_reg[6];
            end
          end
          ST_MACK: begin
            if (scl_rise && sda_s_reg) begin
              state_reg <= ST_IDLE;
            end else if (scl_fall) begin
              sh_reg <= next_byte;
              oe_n_reg <= next_byte[7];
              bit_reg <= COUNT_RESET;
              if (idx_reg != LAST_IDX) begin
                idx_reg <= idx_reg + 4'h1;
              end
              state_reg <= ST_TX;
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // command latch and snapshots
  // ----------------------------------------
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cmd_reg <= CMD_RESET;
    end else if (CE && state_reg == ST_CMD && byte_done) begin
      cmd_reg <= sh_reg;
    end
  end

  // freeze status and position at the read address so the bytes stay coherent; the otp bytes are read live
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      snap_reg <= '0;
      psnap_reg <= '0;
    end else if (CE && state_reg == ST_ADDR && byte_done) begin
      snap_reg <= STATUS;
      psnap_reg <= POSITION;
    end
  end

  // ----------------------------------------
  // fault flag clear
  // ----------------------------------------
  // pulse once the last flag byte has left, so no flag is cleared unreported
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      clr_reg <= 1'b0;
    end else if (CE) begin
      clr_reg <= state_reg == ST_TX && byte_done && cmd_reg == CMD_STATUS
                 && idx_reg == CLEAR_IDX;
    end
  end

  assign FLAG_CLEAR = clr_reg;
  assign SDA_OE_N = oe_n_reg;
  assign SDA_OUT = 1'b0;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  sequence nack_seq;
    CE && state_reg == ST_MACK && scl_rise && sda_s_reg;
  endsequence

  sequence load_seq;
    CE && load_next && !start_ev && !stop_ev;
  endsequence

  addr_match_a: assert property (
    CE && state_reg == ST_ADDR && byte_done && !start_ev && !stop_ev && sh_reg[7:1] == own_addr
    |=> state_reg == ST_AACK && !oe_n_reg) else $error("own address not acknowledged");
  addr_miss_a: assert property (
    CE && state_reg == ST_ADDR && byte_done && !start_ev && !stop_ev && sh_reg[7:1] != own_addr
    |=> state_reg == ST_IDLE && oe_n_reg) else $error("foreign address acknowledged");
  cmd_latch_a: assert property (
    CE && state_reg == ST_CMD && byte_done && !start_ev && !stop_ev
    |=> cmd_reg == $past(sh_reg) && state_reg == ST_CACK) else $error("command byte not latched");
  nack_release_a: assert property (
    nack_seq and !start_ev and !stop_ev |=> state_reg == ST_IDLE && oe_n_reg)
    else $error("line not freed after missing ack");
  flag_clear_a: assert property (
    FLAG_CLEAR |-> cmd_reg == CMD_STATUS && state_reg == ST_MACK && $past(state_reg) == ST_TX)
    else $error("flag clear outside status read");
  stat_current_a: assert property (
    load_seq and cmd_reg == CMD_STATUS and idx_reg == 4'h2
    |=> sh_reg == {snap_reg.run_current, snap_reg.hold_current}) else $error("current byte wrong");
  stat_flags_a: assert property (
    load_seq and cmd_reg == CMD_STATUS and idx_reg == 4'h5
    |=> sh_reg[7] == snap_reg.logic_supply_reset_flag && sh_reg[1:0] == snap_reg.temperature_level)
    else $error("flag byte wrong");
  stat_motion_a: assert property (
    load_seq and cmd_reg == CMD_STATUS and idx_reg == 4'h6
    |=> sh_reg[1] && sh_reg[0] == snap_reg.pump_failure && sh_reg[7:5] == snap_reg.motion_status)
    else $error("motion byte wrong");
  pos_order_a: assert property (
    load_seq and cmd_reg == CMD_POS and idx_reg == 4'h2
    |=> sh_reg == psnap_reg.actual_position[15:8]) else $error("position order wrong");
  sec_pad_a: assert property (
    load_seq and cmd_reg == CMD_POS and idx_reg == 4'h7
    |=> sh_reg[7:3] == SEC_PAD && sh_reg[2:0] == psnap_reg.secure_position[10:8])
    else $error("secure position pad wrong");
  otp_order_a: assert property (
    load_seq and cmd_reg == CMD_OTP and idx_reg == 4'h3
    |=> sh_reg == OTP_BYTES[2]) else $error("otp byte order wrong");
  addr_echo_a: assert property (
    CE && load_first && !start_ev && !stop_ev && cmd_reg == CMD_STATUS
    |=> sh_reg == {ADDR_ECHO_MARK, own_addr[4:0]} ##1 state_reg == ST_TX)
    else $error("address echo wrong");

endmodule

// ===== motor_status_readout_pkg.sv
// shared constants and carriers for the motor status readout block
package motor_status_readout_pkg;

  // ----------------------------------------
  // command codes
  // ----------------------------------------
  localparam logic [7:0] CMD_STATUS = 8'h81;
  localparam logic [7:0] CMD_POS = 8'hFC;
  localparam logic [7:0] CMD_OTP = 8'h82;
  localparam logic [7:0] CMD_RESET = 8'h00;

  // ----------------------------------------
  // framing constants
  // ----------------------------------------
  localparam logic [1:0] ADDR_FIXED = 2'b11;
  localparam logic [2:0] ADDR_ECHO_MARK = 3'b111;
  localparam logic [4:0] SEC_PAD = 5'h1F;
  localparam logic [5:0] STALL_PAD = 6'h3F;
  localparam logic [7:0] FILL_BYTE = 8'hFF;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] FIRST_IDX = 4'h1;
  localparam logic [3:0] LAST_IDX = 4'h9;
  localparam logic [3:0] CLEAR_IDX = 4'h7;
  localparam logic [7:0] SHIFT_RESET = 8'h00;
  localparam logic [3:0] COUNT_RESET = 4'h0;

  typedef logic [7:0][7:0] otp_t;

  // ----------------------------------------
  // status and position carriers
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] run_current;
    logic [3:0] hold_current;
    logic [3:0] max_velocity;
    logic [3:0] min_velocity;
    logic ramp_bypass;
    logic [1:0] microstep_resolution;
    logic direction;
    logic [3:0] acceleration;
    logic logic_supply_reset_flag;
    logic lost_steps_flag;
    logic electrical_defect;
    logic supply_undervoltage;
    logic thermal_shutdown;
    logic thermal_warning;
    logic [1:0] temperature_level;
    logic [2:0] motion_status;
    logic external_switch_state;
    logic overcurrent_x_coil;
    logic overcurrent_y_coil;
    logic pump_failure;
  } status_s;

  typedef struct packed {
    logic [15:0] actual_position;
    logic [15:0] target_position;
    logic [10:0] secure_position;
    logic [1:0] stall_info;
  } position_s;

endpackage

// ===== motor_status_readout_tb.sv
// self-checking bench for the motor status readout block
module motor_status_readout_tb import motor_status_readout_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, sys_rst, sda_out, sda_oe_n, flag_clear, pin_bit, scl, sda_m;
  logic ce;
  logic [3:0] otp_adr;
  status_s status;
  position_s position;
  otp_t otp_bytes;
  logic [6:0] my_adr;
  logic [7:0] echo;
  int bad_count = 0;
  int samples_checked = 0;
  int clear_count = 0;
  // wired-and with the pull-up: an unselected or released slave reads high
  wire sda_line = sda_m & (sda_oe_n | sda_out);

  motor_status_readout dut (.CLOCK(clock), .SYS_RST(sys_rst), .CE(ce), .SCL_IN(scl), .SDA_IN(sda_line),
    .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .OTP_ADDRESS_BITS(otp_adr), .PIN_ADDRESS_BIT(pin_bit),
    .STATUS(status), .POSITION(position), .OTP_BYTES(otp_bytes), .FLAG_CLEAR(flag_clear));
  two_wire_master_model mst (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_drv(sda_m));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // count on the falling edge, where the registered pulse has settled
  always @(negedge clock) begin
    if (flag_clear === 1'b1) clear_count++;
  end

  // ----------------------------------------
  // compare and report
  // ----------------------------------------
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic read_and_check(input logic [7:0] cmd, input int n, input logic [7:0] e [8]);
    logic ok;
    logic [7:0] d [8];
    mst.read_cmd(my_adr, cmd, n, ok, d);
    check1(ok, 1'b1);
    for (int i = 0; i < n; i++) begin
      check8(d[i], e[i]);
    end
    check1(sda_line, 1'b1);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic status_scenario();
    logic [7:0] e [8];
    int c0;
    e = '{echo, {status.run_current, status.hold_current}, {status.max_velocity, status.min_velocity},
      {status.ramp_bypass, status.microstep_resolution, status.direction, status.acceleration},
      {status.logic_supply_reset_flag, status.lost_steps_flag, status.electrical_defect,
       status.supply_undervoltage, status.thermal_shutdown, status.thermal_warning, status.temperature_level},
      {status.motion_status, status.external_switch_state, status.overcurrent_x_coil,
       status.overcurrent_y_coil, 1'b1, status.pump_failure}, 8'hFF, 8'hFF};
    c0 = clear_count;
    read_and_check(CMD_STATUS, 8, e);
    check8(8'(clear_count - c0), 8'h01);
    // a read cut short before the flag byte must not clear anything
    c0 = clear_count;
    read_and_check(CMD_STATUS, 2, e);
    check8(8'(clear_count - c0), 8'h00);
  endtask

  task automatic position_scenario();
    logic [7:0] e [8];
    int c0;
    e = '{echo, position.actual_position[15:8], position.actual_position[7:0],
      position.target_position[15:8], position.target_position[7:0], position.secure_position[7:0],
      {5'h1F, position.secure_position[10:8]}, {6'h3F, position.stall_info}};
    c0 = clear_count;
    read_and_check(CMD_POS, 8, e);
    check8(8'(clear_count - c0), 8'h00);
  endtask

  task automatic otp_scenario();
    logic [7:0] e [8];
    for (int i = 0; i < 8; i++) begin
      e[i] = otp_bytes[i];
    end
    read_and_check(CMD_OTP, 8, e);
  endtask

  task automatic address_scenario();
    logic ok;
    logic [7:0] d [8];
    mst.read_cmd({my_adr[6:1], ~my_adr[0]}, CMD_STATUS, 1, ok, d);
    check1(ok, 1'b0);
    check8(d[0], 8'hFF);
    mst.read_cmd({2'b01, my_adr[4:0]}, CMD_STATUS, 1, ok, d);
    check1(ok, 1'b0);
  endtask

  // with the enable low a whole frame must pass unseen, and the block must pick up cleanly afterwards
  task automatic freeze_scenario();
    logic ok;
    logic [7:0] d [8];
    logic [7:0] e [8];
    int c0;
    for (int i = 0; i < 8; i++) begin
      e[i] = 8'hFF;
    end
    c0 = clear_count;
    ce = 1'b0;
    mst.read_cmd(my_adr, CMD_STATUS, 8, ok, d);
    ce = 1'b1;
    check1(ok, 1'b0);
    check8(d[0], 8'hFF);
    check8(8'(clear_count - c0), 8'h00);
    // an undecoded command is acked but answers with all ones
    read_and_check(8'h55, 8, e);
  endtask

  initial begin
    sys_rst = 1'b1;
    ce = 1'b1;
    otp_adr = 4'hA;
    pin_bit = 1'b1;
    status = 39'h2A_C3E7_1B2D;
    position = {16'h8001, 16'hFFFE, 11'h05A3, 2'h2};
    otp_bytes = 64'h0123_4567_89AB_CDEF;
    my_adr = {2'b11, 4'hA, 1'b1};
    echo = {3'b111, 4'hA, 1'b1};
    repeat (2) @(negedge clock);
    sys_rst = 1'b0;
    repeat (4) @(negedge clock);
    status_scenario();
    position_scenario();
    otp_scenario();
    freeze_scenario();
    address_scenario();
    summarize();
  end

  // hang guard: the whole run is far shorter than this
  initial begin
    repeat (50000) @(posedge clock);
    bad_count++;
    summarize();
  end
endmodule

// ===== two_wire_master_model.sv
// bus master model that drives the two-wire link of the readout block
module two_wire_master_model (
  // system clock used only to pace the bus
  input wire logic clock,
  // bus lines
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------
  // bus phases
  // ----------------------------------------
  // scl stands high between frames; a released data line floats up through the pull-up
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic start_cond();
    sda_drv = 1'b1;
    tick(4);
    sda_drv = 1'b0;
    tick(4);
  endtask

  task automatic stop_cond();
    scl = 1'b0;
    tick(2);
    sda_drv = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_drv = 1'b1;
    tick(4);
  endtask

  // data moves mid low phase and is read at the tail of the high phase, after the slave has settled
  task automatic bit_cycle(input logic b, output logic r);
    scl = 1'b0;
    tick(2);
    sda_drv = b;
    tick(2);
    scl = 1'b1;
    tick(4);
    r = sda_line;
  endtask

  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(d[i], r);
    end
    bit_cycle(1'b1, r);
    ack = ~r;
  endtask

  task automatic read_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, r);
      d[i] = r;
    end
    bit_cycle(last, r);
  endtask

  // ----------------------------------------
  // read transaction
  // ----------------------------------------
  task automatic read_cmd(input logic [6:0] adr, input logic [7:0] cmd, input int n,
                          output logic acked, output logic [7:0] d [8]);
    logic a1, a2, a3;
    start_cond();
    write_byte({adr, 1'b0}, a1);
    write_byte(cmd, a2);
    stop_cond();
    start_cond();
    write_byte({adr, 1'b1}, a3);
    acked = a1 & a2 & a3;
    for (int i = 0; i < 8; i++) begin
      d[i] = 8'h00;
    end
    for (int i = 0; i < n; i++) begin
      read_byte(i == n - 1, d[i]);
    end
    stop_cond();
  endtask
endmodule
